// ---- hw/conv_timer.sv ----
// conversion timer: paces one conversion per resolution-dependent period
`include "temp_sensor_regs.svh"
module conv_timer
	import temp_sensor_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_9 = `CONV_MS_9 * (`CLK_HZ / 1000)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] resolution,
	output logic busy,
	output logic done
);

	// ==========================================================
	// period per resolution: 30/60/120/240 ms scale as doubling
	function automatic logic [31:0] period_of(input logic [1:0] res);
		period_of = 32'(CONV_CYCLES_9) << res;
	endfunction

	conv_state_type state_reg;
	logic [31:0] count_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= CONV_IDLE;
			count_reg <= 32'h0;
		end else begin
			case (state_reg)
				CONV_IDLE: begin
					if (start) begin
						state_reg <= CONV_RUN;
						count_reg <= period_of(resolution) - 32'h1;
					end
				end
				CONV_RUN: begin
					if (count_reg == 32'h0) begin
						state_reg <= CONV_DONE;
					end else begin
						count_reg <= count_reg - 32'h1;
					end
				end
				default: begin
					state_reg <= CONV_IDLE;
				end
			endcase
		end
	end

	assign busy = (state_reg != CONV_IDLE);
	assign done = (state_reg == CONV_DONE);

endmodule

// ---- hw/fault_queue.sv ----
// fault queue: counts consecutive conversions meeting a condition
`include "temp_sensor_regs.svh"
module fault_queue
	import temp_sensor_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sample,
	input wire logic condition,
	input wire logic [1:0] queue_sel,
	output logic hit
);

	// ==========================================================
	// decoded required run length
	function automatic logic [2:0] queue_len(input logic [1:0] sel);
		case (sel)
			2'h0: queue_len = 3'h1;
			2'h1: queue_len = 3'h2;
			2'h2: queue_len = 3'h4;
			default: queue_len = 3'h6;
		endcase
	endfunction

	logic [2:0] run_reg;
	logic [2:0] run_next;

	always_comb begin
		run_next = run_reg;
		if (sample) begin
			if (!condition) begin
				run_next = 3'h0;
			end else if (run_reg < 3'h6) begin
				run_next = run_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_reg <= 3'h0;
		end else begin
			run_reg <= run_next;
		end
	end

	// fires only on the sample that completes (or extends) the run
	assign hit = sample && condition && (run_next >= queue_len(queue_sel));

endmodule

// ---- hw/temp_sensor_core.sv ----
// register file, conversion control and alert logic of the temperature sensor
`include "temp_sensor_regs.svh"
module temp_sensor_core
	import temp_sensor_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_9 = `CONV_MS_9 * (`CLK_HZ / 1000)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [15:0] adc_sample,
	output logic conv_active,
	output logic alert_out,
	output logic alert_oe
);

	// ==========================================================
	// registers
	temp_word_type ambient_reg;
	temp_word_type upper_limit_reg;
	temp_word_type hysteresis_limit_reg;
	logic [7:0] sensor_configuration_reg;
	logic [1:0] pointer_reg;
	logic alert_state_reg;
	logic int_armed_high_reg;
	logic alert_out_reg;
	logic conv_active_reg;
	logic [15:0] rdata_reg;
	logic shutdown_q_reg;

	logic conv_busy;
	logic conv_done;
	logic conv_start;
	logic above_hit;
	logic below_hit;
	logic cfg_shutdown;
	logic cfg_oneshot;
	logic cfg_intmode;
	logic cfg_write;

	assign cfg_shutdown = sensor_configuration_reg[`CFG_SHUTDOWN];
	assign cfg_oneshot = sensor_configuration_reg[`CFG_ONESHOT];
	assign cfg_intmode = sensor_configuration_reg[`CFG_INTMODE];
	assign cfg_write = reg_write && (reg_addr == `PTR_CONFIG);

	// ==========================================================
	// result masking by resolution
	function automatic temp_word_type mask_result(input temp_word_type raw,
			input logic [1:0] res);
		temp_word_type m;
		// each step of resolution keeps one more fraction bit below the half degree
		m = 16'hFF80 | (16'h0070 & ~(16'h0070 >> res));
		mask_result = raw & m & 16'hFFF0;
	endfunction

	// ==========================================================
	// conversion scheduling
	// continuous when shutdown clear; single shot when both set
	assign conv_start = !conv_busy && (!cfg_shutdown || cfg_oneshot);

	conv_timer #(
		.CONV_CYCLES_9(CONV_CYCLES_9)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(conv_start),
		.resolution(sensor_configuration_reg[`CFG_RES_HI:`CFG_RES_LO]),
		.busy(conv_busy),
		.done(conv_done)
	);

	// ==========================================================
	// signed comparisons on the nine-bit limit format
	logic signed [8:0] amb9;
	logic signed [8:0] upper9;
	logic signed [8:0] hyst9;
	assign amb9 = ambient_reg[15:7];
	assign upper9 = upper_limit_reg[15:7];
	assign hyst9 = hysteresis_limit_reg[15:7];

	// comparisons use the fresh result so the queue sees this conversion
	logic signed [8:0] fresh9;
	temp_word_type fresh_word;
	assign fresh_word = mask_result(adc_sample, sensor_configuration_reg[6:5]);
	assign fresh9 = fresh_word[15:7];

	fault_queue u_above (
		.clk(clk),
		.rst_n(rst_n),
		.sample(conv_done),
		.condition(fresh9 > upper9),
		.queue_sel(sensor_configuration_reg[`CFG_QUEUE_HI:`CFG_QUEUE_LO]),
		.hit(above_hit)
	);

	fault_queue u_below (
		.clk(clk),
		.rst_n(rst_n),
		.sample(conv_done),
		.condition(fresh9 < hyst9),
		.queue_sel(sensor_configuration_reg[`CFG_QUEUE_HI:`CFG_QUEUE_LO]),
		.hit(below_hit)
	);

	// ==========================================================
	// ambient result, single register loaded with the masked sample on conversion done
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ambient_reg <= `RST_AMBIENT;
		end else if (conv_done) begin
			ambient_reg <= fresh_word;
		end
	end

	// ==========================================================
	// limit registers and pointer
	// the pointer only mirrors the last address; reads decode reg_addr directly
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upper_limit_reg <= `RST_UPPER;
			hysteresis_limit_reg <= `RST_HYST;
			pointer_reg <= `RST_POINTER;
		end else begin
			if (reg_write || reg_read) begin
				pointer_reg <= reg_addr;
			end
			if (reg_write && reg_addr == `PTR_UPPER) begin
				upper_limit_reg <= {reg_wdata[15:7], 7'h00};
			end else if (reg_write && reg_addr == `PTR_HYST) begin
				hysteresis_limit_reg <= {reg_wdata[15:7], 7'h00};
			end
		end
	end

	// ==========================================================
	// configuration; a same-cycle host write wins over the hardware oneshot clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sensor_configuration_reg <= `RST_CONFIG;
		end else if (cfg_write) begin
			sensor_configuration_reg <= reg_wdata[7:0];
		end else if (conv_done && cfg_shutdown && cfg_oneshot) begin
			sensor_configuration_reg[`CFG_ONESHOT] <= 1'b0;
		end
	end

	// ==========================================================
	// read data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 16'h0000;
		end else if (reg_read) begin
			if (reg_addr == `PTR_AMBIENT) begin
				rdata_reg <= ambient_reg;
			end else if (reg_addr == `PTR_CONFIG) begin
				rdata_reg <= {8'h00, sensor_configuration_reg};
			end else if (reg_addr == `PTR_HYST) begin
				rdata_reg <= hysteresis_limit_reg;
			end else begin
				rdata_reg <= upper_limit_reg;
			end
		end
	end

	// ==========================================================
	// alert state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shutdown_q_reg <= 1'b0;
		end else begin
			shutdown_q_reg <= cfg_shutdown;
		end
	end

	// interrupt events outrank the shutdown clear and the read acknowledge, so a
	// crossing that lands on the acknowledge cycle is never lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alert_state_reg <= 1'b0;
			int_armed_high_reg <= 1'b1;
		end else if (!cfg_intmode) begin
			int_armed_high_reg <= 1'b1;
			if (above_hit) begin
				alert_state_reg <= 1'b1;
			end else if (below_hit && !cfg_shutdown) begin
				alert_state_reg <= 1'b0;
			end
		end else begin
			// events beat a same-cycle read clear
			if (int_armed_high_reg && above_hit) begin
				alert_state_reg <= 1'b1;
				int_armed_high_reg <= 1'b0;
			end else if (!int_armed_high_reg && below_hit) begin
				alert_state_reg <= 1'b1;
				int_armed_high_reg <= 1'b1;
			end else if (cfg_shutdown && !shutdown_q_reg) begin
				alert_state_reg <= 1'b0;
			end else if (reg_read) begin
				alert_state_reg <= 1'b0;
			end
		end
	end

	// push-pull drive: enable tied high, pin always driven
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alert_out_reg <= 1'b1;
		end else begin
			alert_out_reg <= alert_state_reg ~^ sensor_configuration_reg[`CFG_POLARITY];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_active_reg <= 1'b0;
		end else begin
			conv_active_reg <= conv_busy;
		end
	end

	assign alert_out = alert_out_reg;
	assign alert_oe = 1'b1;
	assign reg_rdata = rdata_reg;
	assign conv_active = conv_active_reg;

	// ==========================================================
	// assertions
	a_oneshot_clear: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && cfg_shutdown && cfg_oneshot && !cfg_write |=> !cfg_oneshot)
		else $error("oneshot bit not cleared after conversion");
	a_shutdown_idle: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_shutdown && !cfg_oneshot && !conv_busy |=> !conv_busy)
		else $error("conversion started while shut down");
	a_hyst_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
		hysteresis_limit_reg[6:0] == 7'h00)
		else $error("hysteresis low bits not zero");
	a_comp_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!cfg_intmode && cfg_shutdown && alert_state_reg && !cfg_write |=> alert_state_reg)
		else $error("comparator alert dropped in shutdown");
	a_int_read_clr: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_intmode && alert_state_reg && reg_read && !above_hit && !below_hit && !cfg_write
		|=> !alert_state_reg)
		else $error("interrupt not cleared by read");
	a_polarity_out: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(alert_state_reg) && $stable(sensor_configuration_reg)
		|-> alert_out == (alert_state_reg ~^ sensor_configuration_reg[`CFG_POLARITY]))
		else $error("alert pin polarity wrong");
	a_alert_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(alert_state_reg) |-> $past(above_hit) || $past(below_hit))
		else $error("alert rose without queue hit");
	a_upper_written: assert property (@(posedge clk) disable iff (!rst_n)
		reg_write && reg_addr == `PTR_UPPER |=> upper_limit_reg[15:7] == $past(reg_wdata[15:7]))
		else $error("upper limit write lost");
	a_upper_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
		upper_limit_reg[6:0] == 7'h00)
		else $error("upper limit low bits not zero");
	a_res_nine_bit: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && sensor_configuration_reg[`CFG_RES_HI:`CFG_RES_LO] == 2'h0
		|=> ambient_reg[6:0] == 7'h00)
		else $error("nine-bit result carries finer bits");
	a_ambient_update: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done |=> ambient_reg == $past(fresh_word))
		else $error("ambient result not updated after conversion");
	a_cfg_read_high: assert property (@(posedge clk) disable iff (!rst_n)
		reg_read && reg_addr == `PTR_CONFIG |=> reg_rdata[15:8] == 8'h00)
		else $error("configuration read shows upper byte");
	a_pointer_follow: assert property (@(posedge clk) disable iff (!rst_n)
		reg_write || reg_read |=> pointer_reg == $past(reg_addr))
		else $error("register pointer not updated by access");
	a_int_shutdown_clr: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_intmode && cfg_shutdown && !shutdown_q_reg && !above_hit && !below_hit
		|=> !alert_state_reg)
		else $error("interrupt alert kept on entering shutdown");
	c_oneshot: cover property (@(posedge clk) cfg_shutdown && cfg_oneshot && conv_done);
	c_comp_alert: cover property (@(posedge clk) !cfg_intmode && $rose(alert_state_reg));
	c_int_second: cover property (@(posedge clk) cfg_intmode && below_hit && !int_armed_high_reg);
	c_comp_release: cover property (@(posedge clk)
		!cfg_intmode && amb9 < hyst9 && $fell(alert_state_reg));

endmodule

// ---- hw/temp_sensor_pkg.sv ----
// types shared by the sensor core files
package temp_sensor_pkg;

	typedef enum logic [2:0] {
		CONV_IDLE = 3'b001,
		CONV_RUN = 3'b010,
		CONV_DONE = 3'b100
	} conv_state_type;

	typedef logic [15:0] temp_word_type;

endpackage

// ---- hw/temp_sensor_regs.svh ----
// register offsets, field positions, reset values and timing counts of the sensor core
`ifndef TEMP_SENSOR_REGS_SVH
`define TEMP_SENSOR_REGS_SVH

// ==========================================================
// register pointer values
`define PTR_AMBIENT 2'h0
`define PTR_CONFIG 2'h1
`define PTR_HYST 2'h2
`define PTR_UPPER 2'h3

// ==========================================================
// reset values
`define RST_AMBIENT 16'h0000
`define RST_UPPER 16'hA000
`define RST_HYST 16'h9600
`define RST_CONFIG 8'h00
`define RST_POINTER 2'h0

// ==========================================================
// configuration field positions
`define CFG_ONESHOT 7
`define CFG_RES_HI 6
`define CFG_RES_LO 5
`define CFG_QUEUE_HI 4
`define CFG_QUEUE_LO 3
`define CFG_POLARITY 2
`define CFG_INTMODE 1
`define CFG_SHUTDOWN 0

// ==========================================================
// conversion times
`define CONV_MS_9 30
`define CONV_MS_10 60
`define CONV_MS_11 120
`define CONV_MS_12 240
`define CLK_HZ 10000000

`endif

// ---- verification/host_model.sv ----
// host controller model: single-cycle register writes and reads toward the sensor core
module host_model (
	input wire logic clk,
	output logic [1:0] reg_addr,
	output logic reg_write,
	output logic reg_read,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		reg_addr = 2'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 16'h0000;
	end

	// ==========================================================
	// bus cycles
	task automatic write_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clk);
		#10;
		reg_write = 1'b0;
		// released data must not look like the last word
		reg_wdata = ~d;
	endtask

	// every read doubles as the interrupt acknowledge
	task automatic read_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clk);
		#10;
		d = reg_rdata;
		reg_read = 1'b0;
	endtask
endmodule

// ---- verification/temp_sensor_config_alert_tb.sv ----
// self-checking bench for the sensor core registers, conversion modes and alert
`include "temp_sensor_regs.svh"
module temp_sensor_config_alert_tb
	import temp_sensor_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned CYC9 = 20;
	typedef struct {logic [1:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_type;

	logic clk;
	logic rst_n;
	logic reg_write;
	logic reg_read;
	logic conv_active;
	logic alert_out;
	logic alert_oe;
	logic conv_q;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] adc_sample;
	logic [15:0] rd;
	int error_cnt = 0;
	int samples_checked = 0;
	int fall_cnt = 0;
	int hi_cnt = 0;
	int last_len = 0;
	int f;
	int qcnt [4] = '{1, 2, 4, 6};
	row_type rows [6] = '{
		'{`PTR_HYST, 16'hFFFF, 16'hFF80},
		'{`PTR_HYST, 16'h1234, 16'h1200},
		'{`PTR_UPPER, 16'h7FFF, 16'h7F80},
		'{`PTR_CONFIG, 16'hAB60, 16'h0060},
		'{`PTR_AMBIENT, 16'hFFFF, 16'h0000},
		'{`PTR_CONFIG, 16'h0000, 16'h0000}
	};

	temp_sensor_core #(.CONV_CYCLES_9(CYC9)) dut (
		.clk(clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.adc_sample(adc_sample),
		.conv_active(conv_active),
		.alert_out(alert_out),
		.alert_oe(alert_oe)
	);

	host_model host (
		.clk(clk),
		.reg_addr(reg_addr),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);

	// ==========================================================
	// clock, conversion monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		conv_q <= conv_active;
		if (conv_active === 1'b1) hi_cnt <= hi_cnt + 1;
		if (conv_q === 1'b1 && conv_active === 1'b0) begin
			fall_cnt <= fall_cnt + 1;
			last_len <= hi_cnt;
			hi_cnt <= 0;
		end
	end

	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	// ==========================================================
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic check_alert(input logic exp);
		check({15'h0000, alert_out}, {15'h0000, exp});
	endtask

	task automatic read_chk(input logic [1:0] a, input logic [15:0] exp);
		host.read_reg(a, rd);
		check(rd, exp);
	endtask

	// waits for n finished conversions, then lets the alert pipeline settle
	task automatic wait_conv(input int n);
		int target;
		int k;
		target = fall_cnt + n;
		k = 0;
		while (fall_cnt < target && k < 4000) begin
			@(posedge clk);
			k++;
		end
		if (fall_cnt < target) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, fall_cnt, target);
		end
		repeat (4) @(posedge clk);
		#10;
	endtask

	task automatic reset_check;
		check_alert(1'b1);
		read_chk(`PTR_AMBIENT, 16'h0000);
		read_chk(`PTR_CONFIG, 16'h0000);
		read_chk(`PTR_HYST, 16'h9600);
		read_chk(`PTR_UPPER, 16'hA000);
	endtask

	task automatic end_of_test;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		adc_sample = 16'h0000;
		repeat (16) @(posedge clk);
		#10;
		rst_n = 1'b1;
		reset_check();
		check({15'h0000, alert_oe}, 16'h0001);
		foreach (rows[i]) begin
			host.write_reg(rows[i].addr, rows[i].wdata);
			read_chk(rows[i].addr, rows[i].exp);
		end
		@(posedge clk);
		#10;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#10;
		rst_n = 1'b1;
		reset_check();
		// defaults read as negative limits, so set thresholds of 80 and 75 degrees
		host.write_reg(`PTR_UPPER, 16'h5000);
		host.write_reg(`PTR_HYST, 16'h4B00);
		adc_sample = 16'h1977;
		for (int r = 0; r < 4; r++) begin
			host.write_reg(`PTR_CONFIG, 16'(r << 5));
			wait_conv(2);
			check(16'(last_len >= (CYC9 << r) && last_len <= (CYC9 << r) + 2), 16'h0001);
			read_chk(`PTR_AMBIENT, 16'h1977 & 16'(16'hFFF0 << (3 - r)));
		end
		adc_sample = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			host.write_reg(`PTR_CONFIG, 16'(i << 3));
			wait_conv(2);
			adc_sample = 16'h5080;
			if (qcnt[i] > 1) begin
				wait_conv(qcnt[i] - 1);
				check_alert(1'b1);
			end
			wait_conv(1);
			check_alert(1'b0);
			adc_sample = 16'h0000;
			if (qcnt[i] > 1) begin
				wait_conv(qcnt[i] - 1);
				check_alert(1'b0);
			end
			wait_conv(1);
			check_alert(1'b1);
		end
		host.write_reg(`PTR_CONFIG, 16'h0004);
		repeat (3) @(posedge clk);
		#10;
		check_alert(1'b0);
		host.write_reg(`PTR_CONFIG, 16'h0002);
		wait_conv(1);
		adc_sample = 16'h5080;
		wait_conv(1);
		check_alert(1'b0);
		host.read_reg(`PTR_HYST, rd);
		repeat (2) @(posedge clk);
		#10;
		check_alert(1'b1);
		wait_conv(2);
		check_alert(1'b1);
		adc_sample = 16'h0000;
		wait_conv(1);
		check_alert(1'b0);
		host.read_reg(`PTR_UPPER, rd);
		repeat (2) @(posedge clk);
		#10;
		check_alert(1'b1);
		adc_sample = 16'h5080;
		wait_conv(1);
		check_alert(1'b0);
		host.write_reg(`PTR_CONFIG, 16'h0003);
		repeat (2) @(posedge clk);
		#10;
		check_alert(1'b1);
		adc_sample = 16'h0000;
		host.write_reg(`PTR_CONFIG, 16'h0000);
		wait_conv(2);
		check_alert(1'b1);
		// shutdown alone first, then the single conversion request
		host.write_reg(`PTR_CONFIG, 16'h0001);
		repeat (30) @(posedge clk);
		#10;
		f = fall_cnt;
		adc_sample = 16'h1900;
		repeat (100) @(posedge clk);
		check(16'(fall_cnt), 16'(f));
		read_chk(`PTR_AMBIENT, 16'h0000);
		host.write_reg(`PTR_HYST, 16'h4B7F);
		read_chk(`PTR_HYST, 16'h4B00);
		host.write_reg(`PTR_CONFIG, 16'h0081);
		wait_conv(1);
		read_chk(`PTR_AMBIENT, 16'h1900);
		read_chk(`PTR_CONFIG, 16'h0001);
		f = fall_cnt;
		repeat (60) @(posedge clk);
		check(16'(fall_cnt), 16'(f));
		adc_sample = 16'h2000;
		host.write_reg(`PTR_CONFIG, 16'h0080);
		wait_conv(2);
		read_chk(`PTR_AMBIENT, 16'h2000);
		host.write_reg(`PTR_CONFIG, 16'h0000);
		wait_conv(1);
		adc_sample = 16'h5080;
		wait_conv(1);
		check_alert(1'b0);
		host.write_reg(`PTR_CONFIG, 16'h0001);
		repeat (30) @(posedge clk);
		#10;
		adc_sample = 16'h0000;
		repeat (100) @(posedge clk);
		check_alert(1'b0);
		host.write_reg(`PTR_CONFIG, 16'h0000);
		wait_conv(2);
		check_alert(1'b1);
		end_of_test();
	end
endmodule
